// ===== hdl/cioc_contact_sync.sv
// Contact input synchroniser and rising edge detector
`timescale 1ns/100ps
module cioc_contact_sync (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// Raw contacts in, conditioned view out
	input  wire logic [7:0] raw,
	output      logic [7:0] level,
	output      logic [7:0] rise
);
	import cioc_pkg::*;

	cioc_sync_st_t st_r;
	cioc_sync_st_t st_nxt;

	// Two stage chain, then one more stage for the edge compare
	always_comb begin
		st_nxt      = st_r;
		st_nxt.s1   = raw;
		st_nxt.s2   = st_r.s1;
		st_nxt.prev = st_r.s2;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign level = st_r.s2;

	// One pulse per off-to-on change, per contact
	for (genvar g = 0; g < 8; g++) begin : g_edge
		assign rise[g] = st_r.s2[g] & ~st_r.prev[g];
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	a_single_pulse: assert property (
		(|rise) |=> ((rise & $past(rise)) == 8'h00))
		else $error("contact edge lasted two cycles");

endmodule : cioc_contact_sync

// ===== hdl/cioc_pid_bank.sv
// Storage for eight groups of control tuning parameters
`timescale 1ns/100ps
module cioc_pid_bank (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// Software access, index is group then field
	input  wire logic        wr_en,
	input  wire logic [5:0]  idx,
	input  wire logic [15:0] wr_data,
	output      logic [15:0] rd_data,
	// Active group view
	input  wire logic [2:0]  grp,
	output      logic [15:0] preset,
	output      logic [15:0] lim_lo,
	output      logic [15:0] lim_hi
);
	import cioc_pkg::*;

	// Upper limit opens fully at reset so outputs are not clipped
	localparam cioc_pid_grp_t GRP_RST =
		{PID_RST, PID_RST, PID_OH_RST, {5{PID_RST}}};

	cioc_pid_st_t st_r;
	cioc_pid_st_t st_nxt;

	// Fields 0..5: P, I, D, preset, low limit, high limit
	always_comb begin
		st_nxt = st_r;
		if (wr_en)
			st_nxt.mem[idx[5:3]][idx[2:0]] = wr_data;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			st_r <= {8{GRP_RST}};
		else
			st_r <= st_nxt;
	end

	assign rd_data = st_r.mem[idx[5:3]][idx[2:0]];
	assign preset  = st_r.mem[grp][PID_PO];
	assign lim_lo  = st_r.mem[grp][PID_OL];
	assign lim_hi  = st_r.mem[grp][PID_OH];

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	a_pid_store: assert property (
		(wr_en ##1 (idx == $past(idx))) |-> (rd_data == $past(wr_data)))
		else $error("tuning field did not store written value");

endmodule : cioc_pid_bank

// ===== hdl/cioc_pkg.sv
// Shared types and constants of the contact I/O program control block
package cioc_pkg;

	// Register byte offsets
	localparam logic [5:0] OFS_CMD   = 6'h00;
	localparam logic [5:0] OFS_STAT  = 6'h04;
	localparam logic [5:0] OFS_CFG   = 6'h08;
	localparam logic [5:0] OFS_EVT   = 6'h0C;
	localparam logic [5:0] OFS_IRQS  = 6'h10;
	localparam logic [5:0] OFS_IRQM  = 6'h14;
	localparam logic [5:0] OFS_GRP   = 6'h18;
	localparam logic [5:0] OFS_MAN   = 6'h1C;
	localparam logic [5:0] OFS_AUTO  = 6'h20;
	localparam logic [5:0] OFS_PIDX  = 6'h24;
	localparam logic [5:0] OFS_PDATA = 6'h28;

	// Command bits, interrupt bits
	localparam int CMD_RUN   = 0;
	localparam int CMD_STOP  = 1;
	localparam int IRQ_START = 0;
	localparam int IRQ_STOP  = 1;
	localparam int IRQ_LOCAL = 2;
	localparam int IRQ_PAT   = 3;

	// Type codes
	localparam logic [1:0] OUT_RELAY = 2'h2;
	localparam logic [2:0] RET_OFF   = 3'h0;
	localparam logic [2:0] RET_LOOP  = 3'h4;
	localparam logic [4:0] BANK_OFS  = 5'h10;

	// Tuning group fields
	localparam logic [2:0] PID_PO = 3'h3;
	localparam logic [2:0] PID_OL = 3'h4;
	localparam logic [2:0] PID_OH = 3'h5;
	localparam logic [15:0] PID_RST    = 16'h0000;
	localparam logic [15:0] PID_OH_RST = 16'hFFFF;

	// Reset values
	localparam logic [4:0] PAT_RST = 5'h01;

	typedef enum logic [1:0] {CIOC_RESET, CIOC_RUN, CIOC_LOCAL} cioc_mode_t;

	typedef struct packed {
		logic pattern_bank_input;
		logic local_mode_input;
		logic run_stop_input;
		logic run_start_input;
		logic pattern_select_bit_d;
		logic pattern_select_bit_c;
		logic pattern_select_bit_b;
		logic pattern_select_bit_a;
	} cioc_di_t;

	typedef struct packed {
		logic time_event_d_output;
		logic time_event_c_output;
		logic time_event_b_output;
		logic time_event_a_output;
		logic instrument_alarm_output;
		logic pv_event_b_output;
		logic pv_event_a_output;
	} cioc_do_t;

	typedef struct packed {
		logic [2:0] retransmit_b_type;
		logic [2:0] retransmit_a_type;
		logic [1:0] out_type;
	} cioc_cfg_t;

	typedef struct packed {
		logic        man_en;
		logic [15:0] man_val;
	} cioc_man_t;

	typedef struct packed {
		logic        read;
		logic        write;
		logic [5:0]  address;
		logic [31:0] writedata;
	} cioc_av_req_t;

	typedef struct packed {
		logic        waitrequest;
		logic [31:0] readdata;
	} cioc_av_rsp_t;

	typedef struct packed {
		logic [7:0] s1;
		logic [7:0] s2;
		logic [7:0] prev;
	} cioc_sync_st_t;

	typedef logic [7:0][15:0] cioc_pid_grp_t;

	typedef struct packed {
		logic [7:0][7:0][15:0] mem;
	} cioc_pid_st_t;

	typedef struct packed {
		cioc_mode_t  mode;
		logic [4:0]  pattern;
		cioc_cfg_t   cfg;
		logic [6:0]  evt;
		cioc_do_t    dout;
		logic [3:0]  irq_st;
		logic [3:0]  irq_mask;
		logic        irq;
		logic [2:0]  grp;
		cioc_man_t   man;
		logic [15:0] auto_out;
		logic [5:0]  pidx;
		logic [15:0] out_val;
		logic        loop_en;
		logic        ret_a_en;
		logic        ret_b_en;
		logic        waitreq;
		logic [31:0] rdata;
	} cioc_st_t;

endpackage : cioc_pkg

// ===== hdl/cioc_top.sv
// Contact I/O and program mode control with Avalon-MM registers
//
// Behaviour
// - Select bits weigh 1,2,4,8 into pattern
// - Pattern selection only taken in reset mode
// - Bank input on adds 16 to pattern
// - Start input rising edge begins program run
// - Stop input rising edge stops, drives preset
// - Preset output overrides manual while stopped
// - Local input rising edge enters local mode
// - Outputs 1-3: PV events, instrument alarm
// - Outputs 4-7: time events 1 to 4
// - Eight tuning groups: P, I, D, preset, limits
// - Loop power only at type 4, no retransmit
// - Second retransmit only with relay control output
//
// Design decisions made here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
module cioc_top (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   nrst,
	// Register bus
	input  wire cioc_pkg::cioc_av_req_t av_req,
	output      cioc_pkg::cioc_av_rsp_t av_rsp,
	// Contact inputs, asynchronous pins
	input  wire cioc_pkg::cioc_di_t     contacts,
	// Contact outputs
	output      cioc_pkg::cioc_do_t     contact_out,
	// Control and retransmission terminals
	output      logic [15:0]            control_output_terminal,
	output      logic                   loop_power_en,
	output      logic                   retransmit_a_en,
	output      logic                   retransmit_b_en,
	// Mode and pattern
	output      cioc_pkg::cioc_mode_t   run_mode,
	output      logic [4:0]             selected_pattern_number,
	// Interrupt
	output      logic                   irq
);
	import cioc_pkg::*;

	localparam cioc_st_t ST_RST = '{
		mode:    CIOC_RESET,
		pattern: PAT_RST,
		waitreq: 1'b1,
		default: '0
	};

	cioc_st_t    st_r;
	cioc_st_t    st_nxt;
	cioc_di_t    di_lvl;
	cioc_di_t    di_rise;
	logic        req;
	logic        take;
	logic        wr_do;
	logic        pid_wr;
	logic        start_cmd;
	logic        stop_cmd;
	logic        local_cmd;
	logic [3:0]  sel;
	logic [15:0] pid_rd;
	logic [15:0] preset;
	logic [15:0] lim_lo;
	logic [15:0] lim_hi;

	////////////////////////////////////////////////////////////////////////
	// Submodules

	cioc_contact_sync u_sync (
		.clk   (clk),
		.nrst  (nrst),
		.raw   (contacts),
		.level (di_lvl),
		.rise  (di_rise)
	);

	cioc_pid_bank u_pid (
		.clk     (clk),
		.nrst    (nrst),
		.wr_en   (pid_wr),
		.idx     (st_r.pidx),
		.wr_data (av_req.writedata[15:0]),
		.rd_data (pid_rd),
		.grp     (st_r.grp),
		.preset  (preset),
		.lim_lo  (lim_lo),
		.lim_hi  (lim_hi)
	);

	////////////////////////////////////////////////////////////////////////
	// Bus handshake: fixed one wait cycle, answer on second edge

	assign req    = av_req.read | av_req.write;
	assign take   = req & st_r.waitreq;
	assign wr_do  = av_req.write & ~st_r.waitreq;
	assign pid_wr = wr_do & (av_req.address == OFS_PDATA);

	// Start and stop from contact edges or software keys, local from its contact edge only
	assign start_cmd = di_rise.run_start_input
		| (wr_do & (av_req.address == OFS_CMD)
		& av_req.writedata[CMD_RUN]);
	assign stop_cmd = di_rise.run_stop_input
		| (wr_do & (av_req.address == OFS_CMD)
		& av_req.writedata[CMD_STOP]);
	assign local_cmd = di_rise.local_mode_input;

	// Weights 1,2,4,8 from first to fourth select input
	assign sel = {di_lvl.pattern_select_bit_d, di_lvl.pattern_select_bit_c,
		di_lvl.pattern_select_bit_b, di_lvl.pattern_select_bit_a};

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		logic [31:0] rd_val;
		logic [15:0] v;
		logic [3:0]  ev;
		logic [3:0]  clr;
		rd_val = 32'h0000_0000;
		v      = 16'h0000;
		ev     = 4'h0;
		clr    = 4'h0;
		st_nxt = st_r;

		// Read mux; unmapped offsets read zero, writes dropped
		unique case (av_req.address)
			OFS_STAT: rd_val = {22'h00_0000, st_r.ret_b_en,
				st_r.ret_a_en, st_r.loop_en, st_r.pattern, st_r.mode};
			OFS_CFG:  rd_val = {24'h00_0000, st_r.cfg};
			OFS_EVT:  rd_val = {25'h000_0000, st_r.evt};
			OFS_IRQS: rd_val = {28'h000_0000, st_r.irq_st};
			OFS_IRQM: rd_val = {28'h000_0000, st_r.irq_mask};
			OFS_GRP:  rd_val = {29'h000_0000, st_r.grp};
			OFS_MAN:  rd_val = {15'h0000, st_r.man};
			OFS_AUTO: rd_val = {16'h0000, st_r.auto_out};
			OFS_PIDX: rd_val = {26'h000_0000, st_r.pidx};
			OFS_PDATA: rd_val = {16'h0000, pid_rd};
			default:  rd_val = 32'h0000_0000;
		endcase
		st_nxt.waitreq = ~take;
		if (take & av_req.read)
			st_nxt.rdata = rd_val;

		// Register writes take effect on the answering edge
		if (wr_do) begin
			unique case (av_req.address)
				OFS_CFG:  st_nxt.cfg = av_req.writedata[7:0];
				OFS_EVT:  st_nxt.evt = av_req.writedata[6:0];
				OFS_IRQS: clr = av_req.writedata[3:0];
				OFS_IRQM: st_nxt.irq_mask = av_req.writedata[3:0];
				OFS_GRP:  st_nxt.grp = av_req.writedata[2:0];
				OFS_MAN:  st_nxt.man = av_req.writedata[16:0];
				OFS_AUTO: st_nxt.auto_out = av_req.writedata[15:0];
				OFS_PIDX: st_nxt.pidx = av_req.writedata[5:0];
				default: ;
			endcase
		end

		// Pattern follows the contacts only while in reset mode
		if (st_r.mode == CIOC_RESET && sel != 4'h0) begin
			st_nxt.pattern = {1'b0, sel}
				+ (di_lvl.pattern_bank_input ? BANK_OFS : 5'h00);
			ev[IRQ_PAT] = (st_nxt.pattern != st_r.pattern);
		end

		// Mode: stop outranks start, start outranks local
		if (stop_cmd) begin
			st_nxt.mode    = CIOC_RESET;
			ev[IRQ_STOP]   = 1'b1;
		end else if (start_cmd) begin
			st_nxt.mode    = CIOC_RUN;
			ev[IRQ_START]  = 1'b1;
		end else if (local_cmd) begin
			st_nxt.mode    = CIOC_LOCAL;
			ev[IRQ_LOCAL]  = 1'b1;
		end

		// Control output: preset wins over manual when stopped
		unique case (st_nxt.mode)
			CIOC_RESET: st_nxt.out_val = preset;
			CIOC_RUN, CIOC_LOCAL: begin
				v = st_r.man.man_en ? st_r.man.man_val : st_r.auto_out;
				if (v < lim_lo)
					v = lim_lo;
				if (v > lim_hi)
					v = lim_hi;
				st_nxt.out_val = v;
			end
		endcase

		// Contact outputs mirror event sources one to one
		st_nxt.dout.pv_event_a_output       = st_r.evt[0];
		st_nxt.dout.pv_event_b_output       = st_r.evt[1];
		st_nxt.dout.instrument_alarm_output = st_r.evt[2];
		st_nxt.dout.time_event_a_output     = st_r.evt[3];
		st_nxt.dout.time_event_b_output     = st_r.evt[4];
		st_nxt.dout.time_event_c_output     = st_r.evt[5];
		st_nxt.dout.time_event_d_output     = st_r.evt[6];

		// Shared terminal: loop power excludes retransmission
		st_nxt.loop_en = (st_r.cfg.retransmit_a_type == RET_LOOP)
			| (st_r.cfg.retransmit_b_type == RET_LOOP);
		st_nxt.ret_a_en = ~st_nxt.loop_en
			& (st_r.cfg.retransmit_a_type != RET_OFF);
		st_nxt.ret_b_en = (st_r.cfg.out_type == OUT_RELAY)
			& ~st_nxt.loop_en
			& (st_r.cfg.retransmit_b_type != RET_OFF);

		// Sticky status: a new event beats a same-cycle clear
		st_nxt.irq_st = (st_r.irq_st & ~clr) | ev;
		st_nxt.irq    = |(st_nxt.irq_st & st_nxt.irq_mask);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			st_r <= ST_RST;
		else
			st_r <= st_nxt;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from the state register

	assign av_rsp.waitrequest      = st_r.waitreq;
	assign av_rsp.readdata         = st_r.rdata;
	assign contact_out             = st_r.dout;
	assign control_output_terminal = st_r.out_val;
	assign loop_power_en           = st_r.loop_en;
	assign retransmit_a_en         = st_r.ret_a_en;
	assign retransmit_b_en         = st_r.ret_b_en;
	assign run_mode                = st_r.mode;
	assign selected_pattern_number = st_r.pattern;
	assign irq                     = st_r.irq;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	a_pattern_held: assert property (
		(st_r.mode != CIOC_RESET) |=> $stable(st_r.pattern))
		else $error("pattern changed outside reset mode");

	a_pattern_value: assert property (
		(st_r.mode == CIOC_RESET && sel != 4'h0
			&& !di_lvl.pattern_bank_input)
		|=> (st_r.pattern == {1'b0, $past(sel)}))
		else $error("pattern number not binary of select bits");

	a_bank_add: assert property (
		(st_r.mode == CIOC_RESET && sel != 4'h0
			&& di_lvl.pattern_bank_input)
		|=> (st_r.pattern == ({1'b0, $past(sel)} + BANK_OFS)))
		else $error("bank input did not add sixteen");

	a_start_run: assert property (
		(di_rise.run_start_input && !stop_cmd)
		|=> (st_r.mode == CIOC_RUN))
		else $error("start edge did not begin run");

	a_stop_preset: assert property (
		stop_cmd |=> (st_r.mode == CIOC_RESET
			&& st_r.out_val == $past(preset)))
		else $error("stop did not drive preset output");

	a_preset_over_man: assert property (
		(st_r.mode == CIOC_RESET && st_r.man.man_en)
		|-> (st_r.out_val == $past(preset)))
		else $error("manual value leaked while stopped");

	a_local_entry: assert property (
		(local_cmd && !start_cmd && !stop_cmd)
		|=> (st_r.mode == CIOC_LOCAL))
		else $error("local edge did not enter local mode");

	a_pv_alarm_map: assert property (
		$changed(st_r.evt[2:0])
		|=> (st_r.dout[2:0] == $past(st_r.evt[2:0])))
		else $error("PV event or alarm output mismatch");

	a_time_map: assert property (
		##1 (st_r.dout[6:3] == $past(st_r.evt[6:3])))
		else $error("time event output mismatch");

	a_loop_excl: assert property (
		st_r.loop_en |-> (!st_r.ret_a_en && !st_r.ret_b_en
			&& ($past(st_r.cfg.retransmit_a_type) == RET_LOOP
			|| $past(st_r.cfg.retransmit_b_type) == RET_LOOP)))
		else $error("loop power and retransmission overlap");

	a_retb_relay: assert property (
		st_r.ret_b_en |-> ($past(st_r.cfg.out_type) == OUT_RELAY))
		else $error("second retransmit without relay output");

	a_bus_answer: assert property (
		(req && st_r.waitreq) |=> !st_r.waitreq ##1 st_r.waitreq)
		else $error("bus answer not after one wait cycle");

	c_run_then_stop: cover property (
		(st_r.mode == CIOC_RUN) ##[1:50] (st_r.mode == CIOC_RESET));
	c_bank_pattern: cover property (st_r.pattern > 5'h10);
	c_loop_power: cover property (st_r.loop_en);
	c_irq_raise: cover property ($rose(st_r.irq));

endmodule : cioc_top

// ===== verification/cioc_field_model.sv
// Field switch model that drives the contact pins with a settable lag
`timescale 1ns/100ps
module cioc_field_model (
	// Clock
	input  wire logic               clk,
	// Wanted switch positions and settle lag in cycles
	input  wire logic [7:0]         want,
	input  wire logic [3:0]         lag,
	// Contact pins toward the controller
	output      cioc_pkg::cioc_di_t contacts
);
	import cioc_pkg::*;

	logic [3:0] wait_cnt;

	////////////////////////////////////////////////////////////////////////
	// Start with every switch open
	initial begin
		contacts = '0;
		wait_cnt = '0;
	end

	// Switches move only after the lag, so a slow field is modelled too
	always @(posedge clk) begin
		if (contacts == cioc_di_t'(want)) begin
			wait_cnt <= '0;
		end else if (wait_cnt >= lag) begin
			contacts <= cioc_di_t'(want);
			wait_cnt <= '0;
		end else begin
			wait_cnt <= wait_cnt + 4'h1;
		end
	end
endmodule : cioc_field_model

// ===== verification/cioc_top_tb_top.sv
// Self-checking testbench of the contact I/O program control block
`timescale 1ns/100ps
module cioc_top_tb_top;
	import cioc_pkg::*;

	typedef struct packed {
		logic [7:0] di;
		logic [6:0] evt;
		logic [7:0] cfg;
		logic [4:0] pat;
		logic [2:0] en;
	} cioc_row_t;

	// Contacts, events, config, expected pattern, expected loop/a/b
	localparam cioc_row_t ROWS [8] = '{
		'{8'h01, 7'h01, 8'h06, 5'h01, 3'h2},
		'{8'h02, 7'h02, 8'h26, 5'h02, 3'h3},
		'{8'h04, 7'h04, 8'h24, 5'h04, 3'h2},
		'{8'h08, 7'h08, 8'h12, 5'h08, 3'h4},
		'{8'h0F, 7'h10, 8'h82, 5'h0F, 3'h4},
		'{8'h81, 7'h20, 8'h86, 5'h11, 3'h4},
		'{8'h8F, 7'h40, 8'h00, 5'h1F, 3'h0},
		'{8'h00, 7'h7F, 8'h32, 5'h1F, 3'h4}};

	logic               clk;
	logic               nrst;
	cioc_av_req_t       av_req;
	cioc_av_rsp_t       av_rsp;
	cioc_di_t           contacts;
	cioc_do_t           contact_out;
	logic [15:0]        control_output_terminal;
	logic               loop_power_en;
	logic               retransmit_a_en;
	logic               retransmit_b_en;
	cioc_mode_t         run_mode;
	logic [4:0]         selected_pattern_number;
	logic               irq;
	logic [7:0]         want;
	logic [3:0]         lag;
	logic [31:0]        rd;
	int                 n_fail;
	int                 samples_checked;
	int                 cyc;

	////////////////////////////////////////////////////////////////////////
	cioc_top cioc_top_inst (
		.clk(clk), .nrst(nrst), .av_req(av_req), .av_rsp(av_rsp),
		.contacts(contacts), .contact_out(contact_out),
		.control_output_terminal(control_output_terminal),
		.loop_power_en(loop_power_en), .retransmit_a_en(retransmit_a_en),
		.retransmit_b_en(retransmit_b_en), .run_mode(run_mode),
		.selected_pattern_number(selected_pattern_number), .irq(irq));

	cioc_field_model cioc_field_model_inst (
		.clk(clk), .want(want), .lag(lag), .contacts(contacts));

	////////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial clk = 1'b0;
	always #50 clk = ~clk;

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			end_sim();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Verdict and comparison helpers
	task automatic end_sim();
		if (n_fail == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim

	task automatic chk(input string what, input logic [31:0] seen,
			input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wait_cy(input int n);
		repeat (n) @(posedge clk);
	endtask : wait_cy

	// One bus cycle; holds the request until waitrequest is seen low
	task automatic bus(input logic wr, input logic [5:0] a,
			input logic [31:0] d, output logic [31:0] q);
		av_req.read <= ~wr;
		av_req.write <= wr;
		av_req.address <= a;
		av_req.writedata <= d;
		do @(posedge clk); while (av_rsp.waitrequest !== 1'b0);
		q = av_rsp.readdata;
		av_req.read <= 1'b0;
		av_req.write <= 1'b0;
		// Idle edge so the next request is never driven twice at once
		@(posedge clk);
	endtask : bus

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	// Move the switches and let sync chain plus field lag settle
	task automatic sw(input logic [7:0] v);
		want <= v;
		wait_cy(10);
	endtask : sw

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		nrst = 1'b0;
		av_req = '0;
		want = '0;
		lag = 4'h0;
		n_fail = 0;
		samples_checked = 0;
		cyc = 0;
		wait_cy(12);
		nrst <= 1'b1;
		wait_cy(2);
		chk("mode_rst", 32'(run_mode), 32'(CIOC_RESET));
		chk("pat_rst", 32'(selected_pattern_number), 32'(PAT_RST));
		chk("out_rst", 32'(control_output_terminal),
			32'h0000_0000);
		chk("do_rst", 32'(contact_out), 32'h0000_0000);
		chk("irq_rst", 32'(irq), 32'h0000_0000);
		// Table rows: pattern select, event routing, terminal sharing
		for (int i = 0; i < 8; i++) begin
			wr(OFS_EVT, 32'(ROWS[i].evt));
			wr(OFS_CFG, 32'(ROWS[i].cfg));
			sw(ROWS[i].di);
			chk("pattern", 32'(selected_pattern_number),
				32'(ROWS[i].pat));
			chk("dout", 32'(contact_out), 32'(ROWS[i].evt));
			chk("loop_en", 32'(loop_power_en), 32'(ROWS[i].en[2]));
			chk("ret_a", 32'(retransmit_a_en), 32'(ROWS[i].en[1]));
			chk("ret_b", 32'(retransmit_b_en), 32'(ROWS[i].en[0]));
		end
		bus(1'b0, 6'h2C, 32'h0000_0000, rd);
		chk("unmapped", rd, 32'h0000_0000);
		// Group 0 preset and limits, manual below the low limit
		lag <= 4'h2;
		wr(OFS_PIDX, 32'h0000_0003);
		wr(OFS_PDATA, 32'h0000_1234);
		wr(OFS_PIDX, 32'h0000_0004);
		wr(OFS_PDATA, 32'h0000_0100);
		wr(OFS_PIDX, 32'h0000_0005);
		wr(OFS_PDATA, 32'h0000_0F00);
		wr(OFS_MAN, 32'h0001_0050);
		wr(OFS_IRQM, 32'h0000_0001);
		sw(8'h10);
		chk("mode_run", 32'(run_mode), 32'(CIOC_RUN));
		chk("irq_start", 32'(irq), 32'h0000_0001);
		chk("out_run", 32'(control_output_terminal),
			32'h0000_0100);
		wr(OFS_IRQS, 32'h0000_0001);
		sw(8'h13);
		chk("pat_hold", 32'(selected_pattern_number), 32'h0000_001F);
		chk("irq_once", 32'(irq), 32'h0000_0000);
		sw(8'h33);
		chk("mode_stop", 32'(run_mode), 32'(CIOC_RESET));
		chk("out_pre", 32'(control_output_terminal),
			32'h0000_1234);
		chk("pat_new", 32'(selected_pattern_number), 32'h0000_0003);
		bus(1'b0, OFS_IRQS, 32'h0000_0000, rd);
		chk("irq_st", rd & 32'h0000_0003, 32'h0000_0002);
		chk("irq_mask", 32'(irq), 32'h0000_0000);
		// Last group, its preset takes over while stopped
		wr(OFS_PIDX, 32'h0000_003B);
		wr(OFS_PDATA, 32'h0000_ABCD);
		bus(1'b0, OFS_PDATA, 32'h0000_0000, rd);
		chk("grp7_rd", rd, 32'h0000_ABCD);
		wr(OFS_GRP, 32'h0000_0007);
		wait_cy(3);
		chk("grp7_pre", 32'(control_output_terminal),
			32'h0000_ABCD);
		wr(OFS_IRQM, 32'h0000_0004);
		sw(8'h73);
		chk("mode_loc", 32'(run_mode), 32'(CIOC_LOCAL));
		chk("irq_loc", 32'(irq), 32'h0000_0001);
		// Start and stop together: stop wins
		sw(8'h00);
		sw(8'h30);
		chk("mode_both", 32'(run_mode), 32'(CIOC_RESET));
		wr(OFS_IRQS, 32'h0000_000F);
		wait_cy(2);
		chk("irq_clr", 32'(irq), 32'h0000_0000);
		// Software keys: auto output while running, stop key wins
		wr(OFS_MAN, 32'h0000_0000);
		wr(OFS_AUTO, 32'h0000_0200);
		wr(OFS_CMD, 32'h0000_0001);
		wait_cy(2);
		chk("mode_key", 32'(run_mode), 32'(CIOC_RUN));
		chk("out_auto", 32'(control_output_terminal),
			32'h0000_0200);
		bus(1'b0, OFS_STAT, 32'h0000_0000, rd);
		chk("stat", rd, 32'h0000_008D);
		wr(OFS_CMD, 32'h0000_0003);
		wait_cy(2);
		chk("mode_key_stop", 32'(run_mode), 32'(CIOC_RESET));
		chk("out_key_pre", 32'(control_output_terminal),
			32'h0000_ABCD);
		end_sim();
	end
endmodule : cioc_top_tb_top
